// ### shared/fsi_defines.svh
// Purpose: offsets, field positions and reset values of the fiber irq block
// Assumes: 16-bit management registers, word indexed
// Notes:   included by the package, the decoder, the core and the bench, but not by the pending flag
`ifndef FSI_DEFINES_SVH
`define FSI_DEFINES_SVH

`define FSI_ADDR_W          12
`define FSI_DATA_W          16
`define FSI_NUM_EVENTS      10
`define FSI_OFS_ENABLE      12'hC18
`define FSI_OFS_STATUS      12'hC19
`define FSI_ENABLE_RESET    16'h03FF
`define FSI_STATUS_RESET    16'h0000
`define FSI_RESERVED_MASK   16'hFC00
`define FSI_BIT_BASE_PAGE   0
`define FSI_BIT_NEXT_PAGE   1
`define FSI_BIT_PRIO_FAIL   2
`define FSI_BIT_REM_FAULT   3
`define FSI_BIT_LINK_CHG    4
`define FSI_BIT_RX_EMPTY    5
`define FSI_BIT_RX_FULL     6
`define FSI_BIT_TX_EMPTY    7
`define FSI_BIT_TX_FULL     8
`define FSI_BIT_FAR_FAULT   9

`endif

// ### shared/fsi_pkg.sv
// Purpose: types shared by the fiber irq block
// Assumes: fsi_defines.svh holds every number
// Notes:   event vector bit order matches the register layout
`include "fsi_defines.svh"

package fsi_pkg;

  typedef logic [`FSI_NUM_EVENTS-1:0] fsi_events_t;

  // one management access, as seen by the slave
  typedef struct packed {
    logic [`FSI_ADDR_W-1:0] addr;
    logic [`FSI_DATA_W-1:0] wdata;
    logic                   wr;
    logic                   rd;
  } fsi_req_t;

  typedef enum logic [1:0] {
    FSI_SEL_NONE,
    FSI_SEL_ENABLE,
    FSI_SEL_STATUS
  } fsi_sel_t;

endpackage

// ### logic/fsi_addr_decode.sv
// Purpose: decodes a management address into a register select
// Assumes: addresses are word indices
// Notes:   unmapped addresses yield FSI_SEL_NONE
`timescale 1ns/1ps
`include "fsi_defines.svh"

module fsi_addr_decode
  import fsi_pkg::*;
(
  input  wire logic [`FSI_ADDR_W-1:0] addr,
  output fsi_sel_t                    sel
);

  // plain compare, no partial decode, so aliases never answer
  always_comb begin
    case (addr)
      `FSI_OFS_ENABLE: sel = FSI_SEL_ENABLE;
      `FSI_OFS_STATUS: sel = FSI_SEL_STATUS;
      default:         sel = FSI_SEL_NONE;
    endcase
  end

endmodule

// ### logic/fsi_pending_bit.sv
// Purpose: one sticky pending flag with clear-on-read
// Assumes: event and clear are on ref_clk
// Notes:   an event beside a clear keeps the flag set
`timescale 1ns/1ps

module fsi_pending_bit (
  input  wire logic ref_clk,
  input  wire logic resetn,
  input  wire logic eventIn,
  input  wire logic clearIn,
  output logic      pending_q
);

  // set wins over clear so no event is lost
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pending_q <= 1'b0;
    end else if (eventIn) begin
      pending_q <= 1'b1;
    end else if (clearIn) begin
      pending_q <= 1'b0;
    end
  end

endmodule

// ### logic/fsi_irq_core.sv
// Purpose: enable and pending status for ten fiber/sgmii side events
// Assumes: event inputs are one-cycle pulses on ref_clk; single clock
// Notes:   read data appear in the cycle after the read strobe only
`timescale 1ns/1ps
`include "fsi_defines.svh"

module fsi_irq_core
  import fsi_pkg::*;
#(
  parameter int NUM_EVENTS = `FSI_NUM_EVENTS
) (
  input  wire logic                   ref_clk,
  input  wire logic                   resetn,
  input  wire logic [`FSI_ADDR_W-1:0] regAddr,
  input  wire logic [`FSI_DATA_W-1:0] regWdata,
  input  wire logic                   regWr,
  input  wire logic                   regRd,
  output logic      [`FSI_DATA_W-1:0] regRdata,
  input  wire logic                   far_end_fault,
  input  wire logic                   txFifoFull,
  input  wire logic                   txFifoEmpty,
  input  wire logic                   rxFifoFull,
  input  wire logic                   rxFifoEmpty,
  input  wire logic                   linkChange,
  input  wire logic                   partnerRemoteFault,
  input  wire logic                   priorityResolutionFail,
  input  wire logic                   partnerNextPage,
  input  wire logic                   partnerBasePage,
  output logic                        irqOut
);

  fsi_req_t                 req;
  fsi_sel_t                 sel;
  fsi_events_t              events;
  fsi_events_t              pending;
  logic [NUM_EVENTS-1:0]    enable_q;
  logic [`FSI_DATA_W-1:0]   regRdata_q;
  logic [`FSI_DATA_W-1:0]   regRdata_d;
  logic                     statusRead;
  logic                     enableWrite;

  // bundle the bus lines into one carrier; the decoder takes only its addr field
  assign req = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

  fsi_addr_decode u_decode (
    .addr (req.addr),
    .sel  (sel)
  );

  assign statusRead  = req.rd && (sel == FSI_SEL_STATUS);
  assign enableWrite = req.wr && (sel == FSI_SEL_ENABLE);

  // gather events in register bit order
  always_comb begin
    events                           = '0;
    events[`FSI_BIT_FAR_FAULT]       = far_end_fault;
    events[`FSI_BIT_TX_FULL]         = txFifoFull;
    events[`FSI_BIT_TX_EMPTY]        = txFifoEmpty;
    events[`FSI_BIT_RX_FULL]         = rxFifoFull;
    events[`FSI_BIT_RX_EMPTY]        = rxFifoEmpty;
    events[`FSI_BIT_LINK_CHG]        = linkChange;
    events[`FSI_BIT_REM_FAULT]       = partnerRemoteFault;
    events[`FSI_BIT_PRIO_FAIL]       = priorityResolutionFail;
    events[`FSI_BIT_NEXT_PAGE]       = partnerNextPage;
    events[`FSI_BIT_BASE_PAGE]       = partnerBasePage;
  end

  // enable register; reserved upper bits are not stored at all
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      enable_q <= NUM_EVENTS'(`FSI_ENABLE_RESET);
    end else if (enableWrite) begin
      enable_q <= regWdata[NUM_EVENTS-1:0];
    end
  end

  // one sticky flag per event; pending is recorded even when masked
  genvar gi;
  generate
    for (gi = 0; gi < NUM_EVENTS; gi++) begin : g_pend
      fsi_pending_bit u_pend (
        .ref_clk   (ref_clk),
        .resetn    (resetn),
        .eventIn   (events[gi]),
        .clearIn   (statusRead),
        .pending_q (pending[gi])
      );
    end
  endgenerate

  // read mux; unmapped and reserved bits read zero
  always_comb begin
    regRdata_d = '0;
    if (req.rd) begin
      case (sel)
        FSI_SEL_ENABLE: regRdata_d[NUM_EVENTS-1:0] = enable_q;
        FSI_SEL_STATUS: regRdata_d[NUM_EVENTS-1:0] = pending;
        default:        regRdata_d = '0;
      endcase
    end
  end

  // data stand one cycle then drop to zero
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      regRdata_q <= `FSI_STATUS_RESET;
    end else begin
      regRdata_q <= regRdata_d;
    end
  end
  assign regRdata = regRdata_q;

  // level output, combinational so it drops the cycle a clear lands
  assign irqOut = |(pending & enable_q);

  // checks; all on ref_clk, quiet while reset is low
  enable_reset_a: assert property (
    @(posedge ref_clk)
    $rose(resetn) |-> enable_q == NUM_EVENTS'(`FSI_ENABLE_RESET))
    else $error("enable not at reset value after reset");

  reserved_zero_a: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    $past(regRd) |-> (regRdata & `FSI_RESERVED_MASK) == 16'h0000)
    else $error("reserved read bits not zero");

  sequence stat_read_s;
    statusRead && !(|events);
  endsequence

  read_clears_a: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    stat_read_s |=> pending == '0)
    else $error("status read did not clear pending bits");

  read_returns_a: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    statusRead |=> regRdata[NUM_EVENTS-1:0] == $past(pending))
    else $error("status read returned wrong value");

  event_kept_a: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    (statusRead && events[0]) |=> pending[0])
    else $error("event lost during clearing read");

  irq_level_a: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    irqOut == (|(pending & enable_q)))
    else $error("irq not matching enabled pending bits");

  mask_blocks_a: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    (enable_q[`FSI_BIT_FAR_FAULT] == 1'b0 && pending == 10'h200)
      |-> !irqOut)
    else $error("masked far end fault raised irq");

  enable_write_a: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    enableWrite |=> enable_q == $past(regWdata[NUM_EVENTS-1:0]))
    else $error("enable write not stored");

  sequence evt_then_quiet_s;
    events[4] && !statusRead ##1 !statusRead [*2];
  endsequence

  sticky_hold_a: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    evt_then_quiet_s |-> pending[4])
    else $error("link change pending not sticky");

  rdata_once_a: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    !regRd |=> regRdata == 16'h0000)
    else $error("read data stood longer than one cycle");

  // far end fault: recorded even when masked, gated by its own bit
  far_fault_set_a: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    far_end_fault |=> pending[`FSI_BIT_FAR_FAULT])
    else $error("far end fault not recorded");

  far_fault_gate_a: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    pending == fsi_events_t'(1 << `FSI_BIT_FAR_FAULT)
      |-> irqOut == enable_q[`FSI_BIT_FAR_FAULT])
    else $error("far end fault not gated by its enable bit");

  // tx fifo full, shared by the fiber and sgmii paths
  tx_full_set_a: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    txFifoFull |=> pending[`FSI_BIT_TX_FULL])
    else $error("tx fifo full not recorded");

  tx_full_gate_a: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    pending == fsi_events_t'(1 << `FSI_BIT_TX_FULL)
      |-> irqOut == enable_q[`FSI_BIT_TX_FULL])
    else $error("tx fifo full not gated by its enable bit");

  // tx fifo empty
  tx_empty_set_a: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    txFifoEmpty |=> pending[`FSI_BIT_TX_EMPTY])
    else $error("tx fifo empty not recorded");

  tx_empty_gate_a: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    pending == fsi_events_t'(1 << `FSI_BIT_TX_EMPTY)
      |-> irqOut == enable_q[`FSI_BIT_TX_EMPTY])
    else $error("tx fifo empty not gated by its enable bit");

  // rx fifo full
  rx_full_set_a: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    rxFifoFull |=> pending[`FSI_BIT_RX_FULL])
    else $error("rx fifo full not recorded");

  rx_full_gate_a: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    pending == fsi_events_t'(1 << `FSI_BIT_RX_FULL)
      |-> irqOut == enable_q[`FSI_BIT_RX_FULL])
    else $error("rx fifo full not gated by its enable bit");

  // rx fifo empty
  rx_empty_set_a: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    rxFifoEmpty |=> pending[`FSI_BIT_RX_EMPTY])
    else $error("rx fifo empty not recorded");

  rx_empty_gate_a: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    pending == fsi_events_t'(1 << `FSI_BIT_RX_EMPTY)
      |-> irqOut == enable_q[`FSI_BIT_RX_EMPTY])
    else $error("rx fifo empty not gated by its enable bit");

  // link status change
  link_chg_set_a: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    linkChange |=> pending[`FSI_BIT_LINK_CHG])
    else $error("link change not recorded");

  link_chg_gate_a: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    pending == fsi_events_t'(1 << `FSI_BIT_LINK_CHG)
      |-> irqOut == enable_q[`FSI_BIT_LINK_CHG])
    else $error("link change not gated by its enable bit");

  // partner remote fault
  rem_fault_set_a: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    partnerRemoteFault |=> pending[`FSI_BIT_REM_FAULT])
    else $error("partner remote fault not recorded");

  rem_fault_gate_a: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    pending == fsi_events_t'(1 << `FSI_BIT_REM_FAULT)
      |-> irqOut == enable_q[`FSI_BIT_REM_FAULT])
    else $error("partner remote fault not gated by its enable bit");

  // priority resolution failure
  prio_fail_set_a: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    priorityResolutionFail |=> pending[`FSI_BIT_PRIO_FAIL])
    else $error("priority resolution failure not recorded");

  prio_fail_gate_a: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    pending == fsi_events_t'(1 << `FSI_BIT_PRIO_FAIL)
      |-> irqOut == enable_q[`FSI_BIT_PRIO_FAIL])
    else $error("priority failure not gated by its enable bit");

  // next page received
  next_page_set_a: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    partnerNextPage |=> pending[`FSI_BIT_NEXT_PAGE])
    else $error("next page not recorded");

  next_page_gate_a: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    pending == fsi_events_t'(1 << `FSI_BIT_NEXT_PAGE)
      |-> irqOut == enable_q[`FSI_BIT_NEXT_PAGE])
    else $error("next page not gated by its enable bit");

  // base page received
  base_page_set_a: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    partnerBasePage |=> pending[`FSI_BIT_BASE_PAGE])
    else $error("base page not recorded");

  base_page_gate_a: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    pending == fsi_events_t'(1 << `FSI_BIT_BASE_PAGE)
      |-> irqOut == enable_q[`FSI_BIT_BASE_PAGE])
    else $error("base page not gated by its enable bit");

endmodule

// ### dv/tb_fiber_sgmii_interrupt_logic.sv
// Purpose: self-checking bench for the fiber irq block
// Assumes: the model mirrors enable, pending and read data at every edge
// Notes:   compares run on the falling edge, once outputs have settled
`timescale 1ns/1ps
`include "fsi_defines.svh"

module tb_fiber_sgmii_interrupt_logic
  import fsi_pkg::*;
();
  logic                   ref_clk  = 1'b0;
  logic                   resetn   = 1'b0;
  logic [`FSI_ADDR_W-1:0] regAddr  = '0;
  logic [`FSI_DATA_W-1:0] regWdata = '0;
  logic                   regWr    = 1'b0;
  logic                   regRd    = 1'b0;
  fsi_events_t            evts     = '0;
  logic [`FSI_DATA_W-1:0] regRdata;
  logic                   irqOut;
  logic [`FSI_ADDR_W-1:0] addrSel;
  int                     error_cnt = 0;
  int                     cmp_count = 0;
  int                     cycles    = 0;
  int                     enMdl, pendMdl, rdMdl, i, k, sel;

  fsi_irq_core fsi_irq_core_i (
    .ref_clk               (ref_clk),
    .resetn                (resetn),
    .regAddr               (regAddr),
    .regWdata              (regWdata),
    .regWr                 (regWr),
    .regRd                 (regRd),
    .regRdata              (regRdata),
    .far_end_fault         (evts[9]),
    .txFifoFull            (evts[8]),
    .txFifoEmpty           (evts[7]),
    .rxFifoFull            (evts[6]),
    .rxFifoEmpty           (evts[5]),
    .linkChange            (evts[4]),
    .partnerRemoteFault    (evts[3]),
    .priorityResolutionFail(evts[2]),
    .partnerNextPage       (evts[1]),
    .partnerBasePage       (evts[0]),
    .irqOut                (irqOut)
  );

  // free running 20 MHz clock
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    if (error_cnt == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // one cycle of stimulus; strobes last exactly one edge
  task automatic op(input fsi_events_t ev, input logic wr, input logic rd,
                    input logic [11:0] a, input logic [15:0] d);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= wr;
    regRd    <= rd;
    evts     <= ev;
    @(posedge ref_clk);
  endtask

  // reference model; reads the inputs as the design samples them
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      enMdl   = 32'h3FF;
      pendMdl = 0;
      rdMdl   = 0;
    end else begin
      rdMdl = 0;
      if (regRd && regAddr == `FSI_OFS_ENABLE) rdMdl = enMdl;
      if (regRd && regAddr == `FSI_OFS_STATUS) begin
        rdMdl   = pendMdl;
        pendMdl = 0;
      end
      if (regWr && regAddr == `FSI_OFS_ENABLE)
        enMdl = regWdata & 32'h3FF;
      pendMdl = pendMdl | evts;
    end
  end

  // falling edge keeps the compare clear of the launch edge
  always @(negedge ref_clk) begin
    if (resetn) begin
      check(regRdata, 16'(rdMdl));
      check({15'h0, irqOut}, {15'h0, |(enMdl & pendMdl)});
    end
  end

  // hang guard, far above the expected few thousand cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 10000) begin
      error_cnt++;
      stop_test();
    end
  end

  // directed bit walk, then random traffic with a reset in mid-run
  initial begin
    void'($urandom(32'h6236));
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    op('0, 1'b0, 1'b1, `FSI_OFS_ENABLE, '0);
    op('0, 1'b0, 1'b1, `FSI_OFS_STATUS, '0);
    op('0, 1'b1, 1'b0, `FSI_OFS_ENABLE, 16'hFFFF);
    op('0, 1'b0, 1'b1, `FSI_OFS_ENABLE, '0);
    for (i = 0; i < 10; i++) begin
      op('0, 1'b1, 1'b0, `FSI_OFS_ENABLE, 16'(1 << i));
      op(fsi_events_t'(1 << ((i + 1) % 10)), 1'b0, 1'b0, '0, '0);
      op(fsi_events_t'(1 << i), 1'b0, 1'b0, '0, '0);
      op(fsi_events_t'(1 << i), 1'b0, 1'b1, `FSI_OFS_STATUS, '0);
      op('0, 1'b0, 1'b1, `FSI_OFS_STATUS, '0);
      op('0, 1'b0, 1'b1, `FSI_OFS_STATUS, '0);
    end
    for (i = 0; i < 3000; i++) begin
      k   = $urandom % 4;
      sel = $urandom % 3;
      addrSel = (sel == 0) ? `FSI_OFS_ENABLE :
                (sel == 1) ? `FSI_OFS_STATUS : {4'h1, 8'($urandom)};
      op(fsi_events_t'($urandom & $urandom & $urandom), k == 1, k >= 2,
         addrSel, 16'($urandom));
      if (i == 1500) begin
        resetn <= 1'b0;
        op('0, 1'b0, 1'b0, '0, '0);
        op('0, 1'b0, 1'b0, '0, '0);
        resetn <= 1'b1;
      end
    end
    op('0, 1'b0, 1'b0, '0, '0);
    stop_test();
  end
endmodule
